// *** verilog/fud_defines.svh ***
// Offsets, field positions, codes and reset values of the format decoder
`ifndef FUD_DEFINES_SVH
`define FUD_DEFINES_SVH
`define FUD_AW          5
`define FUD_OFS_CDB_LO  5'h00
`define FUD_OFS_CDB_HI  5'h04
`define FUD_OFS_CTRL    5'h08
`define FUD_OFS_MODELEN 5'h0c
`define FUD_OFS_PARAM   5'h10
`define FUD_OFS_STATUS  5'h14
`define FUD_OFS_PLAN    5'h18
`define FUD_OFS_BLKLEN  5'h1c
`define FUD_CTRL_GO     0
`define FUD_CTRL_COMMIT 1
`define FUD_PRM_MERGE   24
`define FUD_HDR_PRIM_DIS 6
`define FUD_HDR_CERT_DIS 5
`define FUD_HDR_STOP    4
`define FUD_HDR_PATTERN 3
`define FUD_HDR_IMMED   1
`define FUD_OP_FORMAT   8'h04
`define FUD_FF_FULL     2'h0
`define FUD_FF_SIZE     2'h1
`define FUD_FF_NOINIT   2'h2
`define FUD_FF_RSVD     2'h3
`define FUD_DLF_BLOCK   3'h0
`define FUD_DLF_BFI     3'h4
`define FUD_DLF_PHYS    3'h5
`define FUD_KEY_ILLEGAL 4'h5
`define FUD_KEY_MEDIUM  4'h3
`define FUD_ASC_OPCODE  8'h20
`define FUD_ASC_FIELD   8'h24
`define FUD_ASC_UNREC   8'h11
`define FUD_ASCQ_NONE   8'h00
`define FUD_ASCQ_COMBO  8'h09
`define FUD_VENDOR_ERR  16'hf7a7
`define FUD_LEN_512     16'h0200
`define FUD_LEN_4096    16'h1000
`endif

// *** verilog/fud_pkg.sv ***
// Types shared by the format command decoder
package fud_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EVAL = 2'b01,
        ST_DONE = 2'b11
    } fud_st_e;
    typedef struct packed {
        logic       check;
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } fud_sense_s;
    typedef struct packed {
        logic        start;
        logic        discard_grown;
        logic        merge_host;
        logic        defect_mgmt;
        logic        media_init;
        logic        mark_hard;
        logic        prim_disable;
        logic        cert_disable;
        logic        stop_fmt;
        logic        pattern;
        logic        save_disable;
        logic        immed;
        logic [1:0]  protect;
        logic [2:0]  dlf;
        logic [15:0] blk_len;
    } fud_plan_s;
    typedef struct packed {
        fud_st_e     st;
        logic        waitreq;
        logic [31:0] rdata;
        logic [31:0] cdb_lo;
        logic [15:0] cdb_hi;
        logic [24:0] prm;
        logic [15:0] mode_len;
        logic        mode_vld;
        logic [15:0] saved_len;
        logic        done;
        fud_sense_s  sense;
        fud_plan_s   plan;
    } fud_state_s;
endpackage : fud_pkg

// *** verilog/fud_decoder.sv ***
// Format command decoder with an Avalon-MM register slave
// Behaviour
// (R1) Last byte of the command block is the control byte, link at bit 0.
// (R2) Link and flag bits never change execution or status.
// (R3) Multi-byte values are most significant byte first.
// (R4) Operation code 04h in byte 0 selects the format command decode.
// (R5) Byte 1 holds protection, long header, data follows, replace, format. The code refuses a set long header bit as an illegal field.
// (R6) With data follows set the initiator sends a parameter list.
// (R7) Without parameter data fixed defaults apply to the format flags.
// (R8) Replace set: drop grown list, host list becomes grown list.
// (R9) Replace clear: keep grown list and merge any host list.
// (R10) Formats 100b and 101b accepted; 000b refused with descriptors.
// (R11) No parameter data with nonzero format field is an illegal field.
// (R12) Use mode select block length, else the previous format's length.
// (R13) Initiator should issue mode select before formatting.
// (R14) Fast mode 00b does defect management and media initialization.
// (R15) Size-only mode allows only compatible size changes, else refused.
// (R16) Size-only with replace, merge or defects gives bad combination.
// (R17) Size-only from 512 marks lost blocks as hard read errors.
// (R18) Initiator discards grown list after a 5/24/09 refusal.
// (R19) Fast mode 10b does defect management without initialization.
// (R20) Reserved fast mode 11b is an illegal field.
// (R21) Nonzero reserved or vendor bits are an illegal field.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fud_defines.svh"
module fud_decoder
    import fud_pkg::*;
#(
    parameter logic [15:0] INIT_BLK_LEN = `FUD_LEN_4096
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic [`FUD_AW-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic                   avs_waitrequest,
    output logic [31:0]            avs_readdata,
    output fud_plan_s              fmt_plan,
    output fud_sense_s             fmt_sense
);
    fud_state_s s_r;
    fud_state_s s_nxt;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic fud_sense_s mk_sense(
        input logic [3:0] key,
        input logic [7:0] asc,
        input logic [7:0] ascq
    );
        fud_sense_s r;
        r.check = 1'b1;
        r.key   = key;
        r.asc   = asc;
        r.ascq  = ascq;
        return r;
    endfunction : mk_sense

    // Command bytes, byte 0 first in the top lane
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  b4;
    logic [7:0]  b5;
    logic        is_fmt;
    logic        follows;
    logic        replace;
    logic [2:0]  dlf;
    logic [1:0]  fast_format_mode;
    logic        size_only;
    logic        mode_rsvd;
    logic [15:0] dlen;
    logic [7:0]  hdr;
    logic        merge;
    logic        rsv_bad;
    logic        dlf_bad;
    logic        combo_bad;
    logic [15:0] new_len;
    logic        compat;
    assign b0 = s_r.cdb_lo[31:24]; // see (R3)
    assign b1 = s_r.cdb_lo[23:16];
    assign b2 = s_r.cdb_lo[15:8];
    assign b3 = s_r.cdb_lo[7:0];
    assign b4 = s_r.cdb_hi[15:8];
    assign b5 = s_r.cdb_hi[7:0]; // see (R1)
    assign is_fmt  = b0 == `FUD_OP_FORMAT; // see (R4)
    assign follows = b1[4]; // see (R5)
    assign replace = b1[3];
    assign dlf     = b1[2:0];
    assign fast_format_mode = b4[1:0];
    assign size_only = fast_format_mode == `FUD_FF_SIZE;
    assign mode_rsvd = fast_format_mode == `FUD_FF_RSVD;
    assign dlen    = s_r.prm[15:0]; // see (R3)
    assign hdr     = s_r.prm[23:16];
    assign merge   = s_r.prm[`FUD_PRM_MERGE];
    // Flag and link bits of byte 5 are left out on purpose
    assign rsv_bad = b1[5] || (b2 != 8'h00) || (b3 != 8'h00)
                  || (b4[7:2] != 6'h00) || (b5[7:2] != 6'h00); // see (R2)
    assign dlf_bad = follows && !((dlf == `FUD_DLF_BFI)
                  || (dlf == `FUD_DLF_PHYS)
                  || ((dlf == `FUD_DLF_BLOCK) && (dlen == 16'h0000)));
    assign combo_bad = replace || merge || (dlen != 16'h0000);
    assign new_len = s_r.mode_vld ? s_r.mode_len : s_r.saved_len;
    assign compat  = (new_len == s_r.saved_len)
        || ((s_r.saved_len == `FUD_LEN_512) && (new_len == `FUD_LEN_4096))
        || ((s_r.saved_len == `FUD_LEN_4096) && (new_len == `FUD_LEN_512));

    always_comb begin
        logic [31:0] rd_mux;
        rd_mux = 32'h0000_0000;
        s_nxt = s_r;
        s_nxt.plan.start = 1'b0;
        unique case (avs_address)
            `FUD_OFS_CDB_LO:  rd_mux = s_r.cdb_lo;
            `FUD_OFS_CDB_HI:  rd_mux = {16'h0000, s_r.cdb_hi};
            `FUD_OFS_MODELEN: rd_mux = {15'h0000, s_r.mode_vld, s_r.mode_len};
            `FUD_OFS_PARAM:   rd_mux = {7'h00, s_r.prm};
            `FUD_OFS_STATUS:  rd_mux = {s_r.done, s_r.sense.check, 2'h0,
                                        s_r.sense.key, s_r.sense.asc,
                                        s_r.sense.ascq, 6'h00, s_r.st};
            `FUD_OFS_PLAN:    rd_mux = s_r.plan[31:0];
            `FUD_OFS_BLKLEN:  rd_mux = {16'h0000, s_r.saved_len};
            default:          rd_mux = 32'h0000_0000;
        endcase
        unique case (s_r.st)
            ST_EVAL: begin
                s_nxt.st   = ST_DONE;
                s_nxt.done = 1'b1;
                s_nxt.sense = '0;
                if (!is_fmt) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_OPCODE,
                                           `FUD_ASCQ_NONE); // see (R4)
                end else if (rsv_bad || mode_rsvd) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_FIELD,
                                           `FUD_ASCQ_NONE); // see (R20), (R21)
                end else if (!follows && (dlf != 3'h0)) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_FIELD,
                                           `FUD_ASCQ_NONE); // see (R11)
                end else if (dlf_bad) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_FIELD,
                                           `FUD_ASCQ_NONE); // see (R10)
                end else if (size_only && combo_bad) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_FIELD,
                                           `FUD_ASCQ_COMBO); // see (R16)
                end else if (size_only && !compat) begin
                    s_nxt.sense = mk_sense(`FUD_KEY_ILLEGAL, `FUD_ASC_FIELD,
                                           `FUD_ASCQ_NONE); // see (R15)
                end
                s_nxt.plan.start = !s_nxt.sense.check;
                s_nxt.plan.discard_grown = replace; // see (R8)
                s_nxt.plan.merge_host = !replace && follows
                                     && (dlen != 16'h0000); // see (R9)
                s_nxt.plan.defect_mgmt = !size_only; // see (R14)
                s_nxt.plan.media_init =
                    fast_format_mode == `FUD_FF_FULL; // see (R19)
                s_nxt.plan.mark_hard = size_only
                    && (s_r.saved_len == `FUD_LEN_512); // see (R17)
                s_nxt.plan.protect = b1[7:6];
                s_nxt.plan.dlf = dlf;
                s_nxt.plan.blk_len = new_len; // see (R12)
                s_nxt.plan.save_disable = 1'b0;
                if (follows) begin // see (R6)
                    s_nxt.plan.prim_disable = hdr[`FUD_HDR_PRIM_DIS];
                    s_nxt.plan.cert_disable = hdr[`FUD_HDR_CERT_DIS];
                    s_nxt.plan.stop_fmt = hdr[`FUD_HDR_STOP];
                    s_nxt.plan.pattern = hdr[`FUD_HDR_PATTERN];
                    s_nxt.plan.immed = hdr[`FUD_HDR_IMMED];
                end else begin // see (R7)
                    s_nxt.plan.prim_disable = 1'b0;
                    s_nxt.plan.cert_disable = 1'b1;
                    s_nxt.plan.stop_fmt = 1'b1;
                    s_nxt.plan.pattern = 1'b0;
                    s_nxt.plan.immed = 1'b0;
                end
            end
            default: begin
            end
        endcase
        if (s_r.waitreq && (avs_read || avs_write)) begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata = avs_read ? rd_mux : 32'h0000_0000;
        end else if (!s_r.waitreq) begin
            s_nxt.waitreq = 1'b1;
            if (avs_write) begin
                unique case (avs_address)
                    `FUD_OFS_CDB_LO: begin
                        s_nxt.cdb_lo = be_merge(s_r.cdb_lo, avs_writedata,
                                                avs_byteenable);
                    end
                    `FUD_OFS_CDB_HI: begin
                        s_nxt.cdb_hi = 16'(be_merge({16'h0000, s_r.cdb_hi},
                            avs_writedata, avs_byteenable));
                    end
                    `FUD_OFS_MODELEN: begin
                        s_nxt.mode_len = 16'(be_merge(
                            {16'h0000, s_r.mode_len},
                            avs_writedata, avs_byteenable));
                        s_nxt.mode_vld = 1'b1; // see (R12)
                    end
                    `FUD_OFS_PARAM: begin
                        s_nxt.prm = 25'(be_merge({7'h00, s_r.prm},
                            avs_writedata, avs_byteenable));
                    end
                    `FUD_OFS_CTRL: begin
                        if (avs_byteenable[0]
                            && avs_writedata[`FUD_CTRL_COMMIT]
                            && s_r.done && !s_r.sense.check) begin
                            s_nxt.saved_len = s_r.plan.blk_len; // see (R12)
                        end
                        if (avs_byteenable[0]
                            && avs_writedata[`FUD_CTRL_GO]) begin
                            s_nxt.st = ST_EVAL;
                            s_nxt.done = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.waitreq <= 1'b1;
            s_r.saved_len <= INIT_BLK_LEN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_waitrequest = s_r.waitreq;
    assign avs_readdata    = s_r.rdata;
    assign fmt_plan        = s_r.plan;
    assign fmt_sense       = s_r.sense;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence eval_s;
        s_r.st == ST_EVAL;
    endsequence
    sequence field_rej_s;
        s_r.sense.check && (s_r.sense.key == `FUD_KEY_ILLEGAL)
            && (s_r.sense.asc == `FUD_ASC_FIELD);
    endsequence
    sequence ok_pre_s;
        eval_s and (is_fmt && !rsv_bad && !mode_rsvd
            && (follows || (dlf == 3'h0)) && !dlf_bad);
    endsequence

    opcode_select_a: assert property ( // see (R4)
        eval_s and !is_fmt |=> s_r.sense.asc == `FUD_ASC_OPCODE)
        else $error("foreign opcode not refused");
    link_ignored_a: assert property ( // see (R2)
        ok_pre_s and !(size_only && (combo_bad || !compat))
        |=> !s_r.sense.check && s_r.plan.start)
        else $error("check raised without cause");
    reserved_bits_a: assert property ( // see (R21)
        eval_s and (is_fmt && rsv_bad) |=> field_rej_s)
        else $error("reserved bits accepted");
    nodata_field_a: assert property ( // see (R11)
        eval_s and (is_fmt && !rsv_bad && !mode_rsvd
            && !follows && dlf != 3'h0) |=> field_rej_s)
        else $error("format field without data accepted");
    fast_reserved_a: assert property ( // see (R20)
        eval_s and (is_fmt && mode_rsvd) |=> field_rej_s)
        else $error("reserved fast mode accepted");
    fast_combo_a: assert property ( // see (R16)
        ok_pre_s and (size_only && combo_bad)
        |=> field_rej_s and s_r.sense.ascq == `FUD_ASCQ_COMBO)
        else $error("bad fast combination accepted");
    nodata_defaults_a: assert property ( // see (R7)
        eval_s and !follows |=> s_r.plan.cert_disable && s_r.plan.stop_fmt
            && !s_r.plan.prim_disable && !s_r.plan.pattern
            && !s_r.plan.immed && !s_r.plan.save_disable)
        else $error("defaults not applied");
    noinit_mode_a: assert property ( // see (R19)
        ok_pre_s and (fast_format_mode == `FUD_FF_NOINIT) |=> s_r.plan.start
            && s_r.plan.defect_mgmt && !s_r.plan.media_init)
        else $error("no-init mode wrong");
    grown_list_a: assert property ( // see (R8), (R9)
        eval_s |=> s_r.plan.discard_grown == $past(replace)
            && s_r.plan.merge_host == ($past(follows) && !$past(replace)
            && ($past(dlen) != 16'h0000)))
        else $error("grown list handling wrong");
    block_len_a: assert property ( // see (R12)
        eval_s and s_r.mode_vld |=> s_r.plan.blk_len == $past(s_r.mode_len))
        else $error("mode select length not used");
    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not a one-cycle answer");
endmodule : fud_decoder
`default_nettype wire

// *** verif/fud_initiator.sv ***
// Initiator model issuing register-bus cycles to the decoder
`timescale 1ns/1ps
`default_nettype none
module fud_initiator
    import fud_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        cmd_go,
    input  wire logic        cmd_wr,
    input  wire logic [4:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    output logic             cmd_busy,
    output logic [31:0]      cmd_rdata,
    output logic [4:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata
);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cmd_busy       <= 1'b0;
            cmd_rdata      <= 32'h0;
            avs_read       <= 1'b0;
            avs_write      <= 1'b0;
            avs_address    <= 5'h1f;
            avs_writedata  <= 32'hffffffff;
            avs_byteenable <= 4'h0;
        end else if (!cmd_busy && cmd_go) begin
            cmd_busy       <= 1'b1;
            avs_read       <= !cmd_wr;
            avs_write      <= cmd_wr;
            avs_address    <= cmd_addr;
            avs_writedata  <= cmd_wdata;
            avs_byteenable <= 4'hf;
        end else if (cmd_busy && !avs_waitrequest) begin
            // Released lines show the inverse so stale values never match
            cmd_busy       <= 1'b0;
            cmd_rdata      <= avs_readdata;
            avs_read       <= 1'b0;
            avs_write      <= 1'b0;
            avs_address    <= ~avs_address;
            avs_writedata  <= ~avs_writedata;
            avs_byteenable <= 4'h0;
        end
    end
endmodule : fud_initiator
`default_nettype wire

// *** verif/format_unit_cdb_decoder_tb.sv ***
// Self-checking bench of the format command decoder
`timescale 1ns/1ps
`default_nettype none
`include "fud_defines.svh"
module format_unit_cdb_decoder_tb
    import fud_pkg::*;
;
    logic        mclk, rstn, cmd_go, cmd_wr, cmd_busy;
    logic [4:0]  cmd_addr, avs_address;
    logic [31:0] cmd_wdata, cmd_rdata, avs_writedata, avs_readdata;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_byteenable;
    fud_plan_s   fmt_plan;
    fud_sense_s  fmt_sense;
    int          failures, checks_done;
    int          starts = 0;
    logic [31:0] q;
    logic [92:0] bad_tbl [14] = '{
        {32'h08000000, 16'h0000, 25'h0000000, 4'h5, 8'h20, 8'h00},
        {32'h04040000, 16'h0000, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04110000, 16'h0000, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04100000, 16'h0000, 25'h0000004, 4'h5, 8'h24, 8'h00},
        {32'h04000000, 16'h0300, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04000100, 16'h0000, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04000001, 16'h0000, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04000000, 16'h0400, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04000000, 16'h0080, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04200000, 16'h0000, 25'h0000000, 4'h5, 8'h24, 8'h00},
        {32'h04180000, 16'h0100, 25'h0000000, 4'h5, 8'h24, 8'h09},
        {32'h04140000, 16'h0100, 25'h0000008, 4'h5, 8'h24, 8'h09},
        {32'h04000000, 16'h0100, 25'h1000000, 4'h5, 8'h24, 8'h09},
        {32'h04000000, 16'h0100, 25'h0000000, 4'h5, 8'h24, 8'h00}};

    fud_decoder fud_decoder_i (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .fmt_plan(fmt_plan),
        .fmt_sense(fmt_sense));
    fud_initiator fud_initiator_i (.mclk(mclk), .rstn(rstn),
        .cmd_go(cmd_go), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_rdata(cmd_rdata),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (fmt_plan.start === 1'b1) starts <= starts + 1;
    end

    task automatic tally_and_finish;
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge mclk);
        cmd_go    <= 1'b1;
        cmd_wr    <= wr;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_go <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            #1;
            if (cmd_busy === 1'b0) break;
        end
        if (n == 50) begin
            failures++;
            tally_and_finish();
        end
        r = cmd_rdata;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd

    // Sends one command block, waits for the decode, returns status and plan
    task automatic run(input logic [31:0] lo, input logic [15:0] hi,
                       input logic [24:0] prm, input logic ok,
                       output logic [31:0] st, output logic [31:0] pl);
        int n;
        int s0;
        wr(`FUD_OFS_CDB_LO, lo);
        wr(`FUD_OFS_CDB_HI, {16'h0, hi});
        wr(`FUD_OFS_PARAM, {7'h0, prm});
        s0 = starts;
        wr(`FUD_OFS_CTRL, 32'h1);
        for (n = 0; n < 20; n++) begin
            bus(1'b0, `FUD_OFS_STATUS, 32'h0, st);
            if (st[31] === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            tally_and_finish();
        end
        bus(1'b0, `FUD_OFS_PLAN, 32'h0, pl);
        check(32'(starts - s0), {31'h0, ok});
    endtask : run

    function automatic fud_plan_s pexp(input logic dis, mer, dm, mi, mh,
        input logic pri, cer, stp, imm, input logic [2:0] dlf,
        input logic [15:0] len);
        fud_plan_s p;
        p = '0;
        p.discard_grown = dis;
        p.merge_host    = mer;
        p.defect_mgmt   = dm;
        p.media_init    = mi;
        p.mark_hard     = mh;
        p.prim_disable  = pri;
        p.cert_disable  = cer;
        p.stop_fmt      = stp;
        p.immed         = imm;
        p.dlf           = dlf;
        p.blk_len       = len;
        return p;
    endfunction : pexp

    task automatic scen_ok(input logic [31:0] lo, input logic [15:0] hi,
                           input logic [24:0] prm, input fud_plan_s ep);
        logic [31:0] st, pl;
        run(lo, hi, prm, 1'b1, st, pl);
        check(st, 32'h80000003);
        check(pl, ep[31:0]);
        check(fmt_plan[31:0], ep[31:0]);
        check({11'h0, fmt_sense}, 32'h0);
    endtask : scen_ok

    task automatic scen_bad(input logic [31:0] lo, input logic [15:0] hi,
        input logic [24:0] prm, input logic [3:0] k, input logic [7:0] c,
        input logic [7:0] cq);
        logic [31:0] st, pl;
        run(lo, hi, prm, 1'b0, st, pl);
        check(st, {2'b11, 2'b00, k, c, cq, 8'h03});
        check({11'h0, fmt_sense}, {11'h0, 1'b1, k, c, cq});
    endtask : scen_bad

    initial begin
        {rstn, cmd_go, cmd_wr, cmd_addr, cmd_wdata} = '0;
        {failures, checks_done} = '0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rd(`FUD_OFS_BLKLEN, 32'h00001000);
        rd(`FUD_OFS_STATUS, 32'h0);
        rd(`FUD_OFS_PLAN, 32'h0);
        wr(5'h03, 32'hffffffff);
        rd(`FUD_OFS_CDB_LO, 32'h0);
        rd(5'h02, 32'h0);
        scen_ok(32'h04000000, 16'h0000, 25'h0, pexp(0, 0, 1, 1, 0, 0, 1, 1,
            0, 3'h0, 16'h1000));
        scen_ok(32'h04000000, 16'h0003, 25'h0720000, pexp(0, 0, 1, 1, 0, 0,
            1, 1, 0, 3'h0, 16'h1000));
        // Parameter list is staged before the command when data follows
        scen_ok(32'h049c0000, 16'h0000, 25'h0420010, pexp(1, 0, 1, 1, 0, 1,
            0, 0, 1, 3'h4, 16'h1000)
            | 33'h0_0010_0000);
        scen_ok(32'h04150000, 16'h0000, 25'h0300008, pexp(0, 1, 1, 1, 0, 0,
            1, 1, 0, 3'h5, 16'h1000));
        scen_ok(32'h04000000, 16'h0200, 25'h0, pexp(0, 0, 1, 0, 0, 0, 1, 1,
            0, 3'h0, 16'h1000));
        wr(`FUD_OFS_MODELEN, 32'h00000400);
        rd(`FUD_OFS_MODELEN, 32'h00010400);
        for (int i = 0; i < 14; i++) begin
            scen_bad(bad_tbl[i][92:61], bad_tbl[i][60:45],
                bad_tbl[i][44:20], bad_tbl[i][19:16],
                bad_tbl[i][15:8], bad_tbl[i][7:0]);
        end
        wr(`FUD_OFS_CTRL, 32'h2);
        rd(`FUD_OFS_BLKLEN, 32'h00001000);
        wr(`FUD_OFS_MODELEN, 32'h00000200);
        // Grown list dropped by a full format before the size change retry
        scen_ok(32'h04080000, 16'h0000, 25'h0, pexp(1, 0, 1, 1, 0, 0, 1, 1,
            0, 3'h0, 16'h0200));
        scen_ok(32'h04000000, 16'h0100, 25'h0, pexp(0, 0, 0, 0, 0, 0, 1, 1,
            0, 3'h0, 16'h0200));
        wr(`FUD_OFS_CTRL, 32'h2);
        rd(`FUD_OFS_BLKLEN, 32'h00000200);
        wr(`FUD_OFS_MODELEN, 32'h00001000);
        scen_ok(32'h04000000, 16'h0100, 25'h0, pexp(0, 0, 0, 0, 1, 0, 1, 1,
            0, 3'h0, 16'h1000));
        tally_and_finish();
    end
endmodule : format_unit_cdb_decoder_tb
`default_nettype wire
